// file: src/sdc_device.sv
`timescale 1ns/100ps
// Behaviour
// - output equals crystal/16 times loop over output divider
// - host keeps loop divider within 200..400 (sdc_host does not check it and passes any 9-bit value)
// - output select 00/01/10/11 divides 1/2/4/8
// - parallel strobe rise captures loop and output
// - parallel strobe low makes latches transparent
// - serial data shifts into 14-bit register
// - shift register samples on serial clock rise
// - serial load works only with parallel strobe high
// - stream order monitor, output, loop divider bits
// - each field sent most significant bit first
// - serial load falling edge latches new values
// - serial load high passes shift contents through
// - parallel path has precedence over serial path
// - monitor select writable only through serial stream
// - parallel strobe low forces monitor select 000
// - monitor pin source chosen by select code
// - code 110 bypasses loop with serial clock
// - bypass output divider ratio at least two
// - loop counter monitor need not be 50% duty
// - strobe low resets monitor latch, shows top bit
module sdc_device
   import sdc_pkg::*;
#(
   parameter int LOOP_WIDTH = 9,
   parameter int VCO_WRAP   = 512
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // link
   sdc_link_if.dev          link,
   // configuration view
   output logic [8:0]       loop_cfg,
   output logic [1:0]       odiv_cfg,
   output logic [2:0]       mon_cfg,
   output logic             bypass
);
   localparam int SYNC_W = 3 + LOOP_WIDTH + ODIV_W + 1;
   localparam logic [3:0]  REF_HALF = 4'(REF_DIV / 2);
   localparam logic [10:0] VCO_LIM  = 11'(VCO_WRAP);

   // pin synchronisers
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic              sclk_d_reg;
   wire  [SYNC_W-1:0] pins = {link.ser_clk, link.ser_data, link.ser_load,
                              link.loop_par, link.odiv_par, link.par_load};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg  <= '0;
         sync2_reg  <= '0;
         sclk_d_reg <= 1'b0;
      end else if (ce) begin
         sync1_reg  <= pins;
         sync2_reg  <= sync1_reg;
         sclk_d_reg <= sync2_reg[SYNC_W-1];
      end
   end

   wire                  sclk_s    = sync2_reg[SYNC_W-1];
   wire                  sdata_s   = sync2_reg[SYNC_W-2];
   wire                  sload_s   = sync2_reg[SYNC_W-3];
   wire [LOOP_WIDTH-1:0] loop_s    = sync2_reg[ODIV_W+LOOP_WIDTH:ODIV_W+1];
   wire [1:0]            odiv_s    = sync2_reg[ODIV_W:1];
   wire                  par_load_s = sync2_reg[0];
   wire                  parallel_strobe_low_reset = ~par_load_s;
   wire                  sclk_rise = sclk_s && !sclk_d_reg;

   // serial shift register
   logic [SHIFT_W-1:0] shift_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= '0;
      end else if (ce) begin
         if (sclk_rise && par_load_s) begin
            shift_reg <= {shift_reg[SHIFT_W-2:0], sdata_s};
         end
      end
   end

   // configuration latches
   logic [LOOP_WIDTH-1:0] loop_reg;
   logic [1:0]            odiv_reg;
   logic [2:0]            mon_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_reg <= '0;
         odiv_reg <= '0;
         mon_reg  <= '0;
      end else if (ce) begin
         if (parallel_strobe_low_reset) begin
            loop_reg <= loop_s;
            odiv_reg <= odiv_s;
            mon_reg  <= MON_SHIFT_OUT;
         end else if (sload_s) begin
            loop_reg <= shift_reg[SH_LOOP_LSB +: LOOP_WIDTH];
            odiv_reg <= shift_reg[SH_ODIV_LSB +: ODIV_W];
            mon_reg  <= shift_reg[SH_MON_LSB +: MON_W];
         end
      end
   end

   wire bypass_on = (mon_reg == MON_BYPASS);

   // divided reference: crystal (pclk) over sixteen
   logic ref_wave;

   sdc_divider #(.W(4)) u_ref (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (1'b1),
      .modulus (REF_HALF),
      .wave    (ref_wave),
      .wrap    (),
      .first   ()
   );

   // oscillator model: one edge tick per overflow, scaled down by VCO_WRAP/16
   logic [10:0] acc_reg;
   logic        vco_tick_reg;
   wire  [10:0] acc_sum  = acc_reg + 11'(loop_reg);
   wire         acc_over = acc_sum >= VCO_LIM;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg      <= '0;
         vco_tick_reg <= 1'b0;
      end else if (ce) begin
         acc_reg      <= acc_over ? acc_sum - VCO_LIM : acc_sum;
         vco_tick_reg <= acc_over;
      end
   end

   // divider source and moduli
   wire       div_tick   = bypass_on ? sclk_rise : vco_tick_reg;
   wire [3:0] odiv_ratio = 4'h1 << odiv_reg;
   wire [3:0] odiv_mod   = (bypass_on && odiv_ratio < 4'(BYPASS_MIN_DIV)) ?
                           4'(BYPASS_MIN_DIV) : odiv_ratio;

   logic fout_wave;
   logic fout_wrap;
   logic fout4_wave;
   logic loop_first;

   sdc_divider #(.W(4)) u_out (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (div_tick),
      .modulus (odiv_mod),
      .wave    (fout_wave),
      .wrap    (fout_wrap),
      .first   ()
   );

   sdc_divider #(.W(LOOP_WIDTH)) u_loop (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (div_tick),
      .modulus (loop_reg),
      .wave    (),
      .wrap    (),
      .first   (loop_first)
   );

   sdc_divider #(.W(3)) u_fout4 (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (fout_wrap),
      .modulus (3'(MON_FOUT_DIV)),
      .wave    (fout4_wave),
      .wrap    (),
      .first   ()
   );

   wire bypass_loop_count = bypass_on & loop_first;

   // monitor source selection
   logic mon_sel;

   always_comb begin
      unique case (mon_reg)
         MON_SHIFT_OUT: mon_sel = shift_reg[SHIFT_W-1];
         MON_HIGH:      mon_sel = 1'b1;
         MON_REF:       mon_sel = ref_wave;
         MON_LOOP:      mon_sel = loop_first;
         MON_FOUT:      mon_sel = fout_wave;
         MON_LOW:       mon_sel = 1'b0;
         MON_BYPASS:    mon_sel = bypass_loop_count;
         MON_FOUT4:     mon_sel = fout4_wave;
      endcase
   end

   // output flops
   logic monitor_reg;
   logic synth_reg;
   logic synth_n_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor_reg <= 1'b0;
         synth_reg   <= 1'b0;
         synth_n_reg <= 1'b1;
      end else if (ce) begin
         monitor_reg <= mon_sel;
         synth_reg   <= fout_wave;
         synth_n_reg <= ~fout_wave;
      end
   end

   assign link.monitor     = monitor_reg;
   assign link.synth_out   = synth_reg;
   assign link.synth_out_n = synth_n_reg;
   assign loop_cfg         = 9'(loop_reg);
   assign odiv_cfg         = odiv_reg;
   assign mon_cfg          = mon_reg;
   assign bypass           = bypass_on;
endmodule

// file: src/sdc_pkg.sv
package sdc_pkg;
   // clock
   localparam int CLK_MHZ          = 100;
   // field widths
   localparam int LOOP_W           = 9;
   localparam int ODIV_W           = 2;
   localparam int MON_W            = 3;
   localparam int SHIFT_W          = 14;
   // shift register field positions
   localparam int SH_LOOP_LSB      = 0;
   localparam int SH_ODIV_LSB      = 9;
   localparam int SH_MON_LSB       = 11;
   // crystal pre-divider and model scaling
   localparam int REF_DIV          = 16;
   localparam int VCO_SCALE        = 32;
   localparam int BYPASS_MIN_DIV   = 2;
   localparam int MON_FOUT_DIV     = 4;
   // monitor select codes
   localparam logic [2:0] MON_SHIFT_OUT = 3'h0;
   localparam logic [2:0] MON_HIGH      = 3'h1;
   localparam logic [2:0] MON_REF       = 3'h2;
   localparam logic [2:0] MON_LOOP      = 3'h3;
   localparam logic [2:0] MON_FOUT      = 3'h4;
   localparam logic [2:0] MON_LOW       = 3'h5;
   localparam logic [2:0] MON_BYPASS    = 3'h6;
   localparam logic [2:0] MON_FOUT4     = 3'h7;
   // link timing in ns and derived cycle counts (least times round up)
   localparam int T_SCLK_HALF_NS   = 50;
   localparam int T_LOAD_SETUP_NS  = 20;
   localparam int T_LOAD_PW_NS     = 50;
   localparam int SCLK_HALF_CYC    = (T_SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int LOAD_SETUP_CYC   = (T_LOAD_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int LOAD_PW_CYC      = (T_LOAD_PW_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W            = 4;
   // host register map
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_PAR      = 8'h04;
   localparam logic [7:0] REG_SER      = 8'h08;
   localparam logic [7:0] REG_STAT     = 8'h0c;
   localparam int CTRL_PLOAD_BIT   = 0;
   localparam int PAR_LOOP_LSB     = 0;
   localparam int PAR_ODIV_LSB     = 9;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_MON_BIT     = 1;
   // reset values
   localparam logic [8:0]  PAR_LOOP_RST = 9'h0c8;
   localparam logic [1:0]  PAR_ODIV_RST = 2'h0;
   localparam logic [13:0] SER_RST      = 14'h0000;
   typedef enum logic [1:0] {SDC_IDLE, SDC_LOW, SDC_HIGH, SDC_LOAD} sdc_host_state_e;
endpackage

// file: src/sdc_link_if.sv
`timescale 1ns/100ps
interface sdc_link_if;
   logic       par_load;
   logic [8:0] loop_par;
   logic [1:0] odiv_par;
   logic       ser_clk;
   logic       ser_data;
   logic       ser_load;
   logic       monitor;
   logic       synth_out;
   logic       synth_out_n;
   modport dev (
      input  par_load, loop_par, odiv_par, ser_clk, ser_data, ser_load,
      output monitor, synth_out, synth_out_n
   );
   modport host (
      output par_load, loop_par, odiv_par, ser_clk, ser_data, ser_load,
      input  monitor, synth_out, synth_out_n
   );
endinterface

// file: src/sdc_divider.sv
`timescale 1ns/100ps
// counts ticks modulo modulus; toggles wave and pulses wrap at each wrap
module sdc_divider #(
   parameter int W = 9
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // control
   input  wire logic         tick,
   input  wire logic [W-1:0] modulus,
   // outputs
   output logic              wave,
   output logic              wrap,
   output logic              first
);
   logic [W-1:0] cnt_reg;
   logic         wave_reg;
   logic         wrap_reg;
   wire  [W:0]   cnt_inc = {1'b0, cnt_reg} + {{W{1'b0}}, 1'b1};
   wire          at_end  = cnt_inc >= {1'b0, modulus};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= '0;
         wave_reg <= 1'b0;
         wrap_reg <= 1'b0;
      end else if (ce) begin
         wrap_reg <= tick && at_end;
         if (tick) begin
            cnt_reg  <= at_end ? '0 : cnt_inc[W-1:0];
            wave_reg <= at_end ? ~wave_reg : wave_reg;
         end
      end
   end

   assign wave  = wave_reg;
   assign wrap  = wrap_reg;
   assign first = (cnt_reg == '0);
endmodule

// file: src/sdc_host.sv
`timescale 1ns/100ps
// host: APB registers drive the parallel pins and a serial loader
module sdc_host
   import sdc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   sdc_link_if.host         link
);
   sdc_host_state_e state_reg;
   logic            pload_reg;
   logic [8:0]      loop_reg;
   logic [1:0]      odiv_reg;
   logic [13:0]     ser_reg;
   logic [13:0]     shift_reg;
   logic [3:0]      bit_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic            sclk_reg;
   logic            sload_reg;
   logic            mon1_reg;
   logic            mon2_reg;
   logic [31:0]     rdata_reg;

   wire busy     = (state_reg != SDC_IDLE);
   wire access   = psel && penable && ce;
   wire wr       = access && pwrite;
   wire hit_ctrl = (paddr == REG_CTRL);
   wire hit_par  = (paddr == REG_PAR);
   wire hit_ser  = (paddr == REG_SER);
   wire hit_stat = (paddr == REG_STAT);
   wire mapped   = hit_ctrl || hit_par || hit_ser || hit_stat;
   wire ser_go   = wr && hit_ser && !busy;
   wire tmr_done = (tmr_reg == '0);

   localparam logic [TMR_W-1:0] HALF_LD  = TMR_W'(SCLK_HALF_CYC - 1);
   localparam logic [TMR_W-1:0] SETUP_LD = TMR_W'(LOAD_SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] PW_LD    = TMR_W'(LOAD_PW_CYC - 1);

   // register file and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pload_reg <= 1'b0;
         loop_reg  <= PAR_LOOP_RST;
         odiv_reg  <= PAR_ODIV_RST;
         ser_reg   <= SER_RST;
         rdata_reg <= '0;
      end else if (ce) begin
         if (wr && hit_ctrl) begin
            pload_reg <= pwdata[CTRL_PLOAD_BIT];
         end
         if (wr && hit_par) begin
            loop_reg <= pwdata[PAR_LOOP_LSB +: 9];
            odiv_reg <= pwdata[PAR_ODIV_LSB +: 2];
         end
         if (ser_go) begin
            ser_reg <= pwdata[13:0];
         end
         if (psel && !penable && !pwrite) begin
            rdata_reg <= '0;
            if (hit_ctrl) rdata_reg[CTRL_PLOAD_BIT] <= pload_reg;
            if (hit_par) rdata_reg[10:0] <= {odiv_reg, loop_reg};
            if (hit_ser) rdata_reg[13:0] <= ser_reg;
            if (hit_stat) rdata_reg[STAT_MON_BIT:STAT_BUSY_BIT] <= {mon2_reg, busy};
         end
      end
   end

   // serial loader: stream goes out most significant bit first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SDC_IDLE;
         shift_reg <= '0;
         bit_reg   <= '0;
         tmr_reg   <= '0;
         sclk_reg  <= 1'b0;
         sload_reg <= 1'b0;
         mon1_reg  <= 1'b0;
         mon2_reg  <= 1'b0;
      end else if (ce) begin
         mon1_reg <= link.monitor;
         mon2_reg <= mon1_reg;
         if (!tmr_done) tmr_reg <= tmr_reg - 1'b1;
         unique case (state_reg)
            SDC_IDLE: begin
               if (ser_go) begin
                  shift_reg <= pwdata[13:0];
                  bit_reg   <= 4'(SHIFT_W - 1);
                  tmr_reg   <= HALF_LD;
                  state_reg <= SDC_LOW;
               end
            end
            SDC_LOW: begin
               if (tmr_done) begin
                  sclk_reg  <= 1'b1;
                  tmr_reg   <= HALF_LD;
                  state_reg <= SDC_HIGH;
               end
            end
            SDC_HIGH: begin
               if (tmr_done) begin
                  sclk_reg <= 1'b0;
                  if (bit_reg == '0) begin
                     tmr_reg   <= SETUP_LD;
                     state_reg <= SDC_LOAD;
                  end else begin
                     shift_reg <= {shift_reg[12:0], 1'b0};
                     bit_reg   <= bit_reg - 1'b1;
                     tmr_reg   <= HALF_LD;
                     state_reg <= SDC_LOW;
                  end
               end
            end
            SDC_LOAD: begin
               if (tmr_done && !sload_reg) begin
                  sload_reg <= 1'b1;
                  tmr_reg   <= PW_LD;
               end else if (tmr_done) begin
                  sload_reg <= 1'b0;
                  state_reg <= SDC_IDLE;
               end
            end
         endcase
      end
   end

   assign pready        = 1'b1;
   assign pslverr       = psel && penable && (!mapped || (pwrite && hit_ser && busy));
   assign prdata        = rdata_reg;
   assign link.par_load = pload_reg;
   assign link.loop_par = loop_reg;
   assign link.odiv_par = odiv_reg;
   assign link.ser_clk  = sclk_reg;
   assign link.ser_data = shift_reg[13];
   assign link.ser_load = sload_reg;
endmodule

// file: tb/sdc_link_sva.sv
`timescale 1ns/100ps
module sdc_link_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   input wire logic par_load,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic synth_out,
   input wire logic synth_out_n
);
   logic       clk_d_reg;
   logic       load_d_reg;
   logic [4:0] rise_cnt_reg;

   // counts shift clock rises since the last load pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d_reg    <= 1'b0;
         load_d_reg   <= 1'b0;
         rise_cnt_reg <= 5'h00;
      end else begin
         clk_d_reg  <= ser_clk;
         load_d_reg <= ser_load;
         if (load_d_reg && !ser_load) begin
            rise_cnt_reg <= 5'h00;
         end else if (!clk_d_reg && ser_clk) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pair_complement: assert property (synth_out_n == !synth_out)
      else $error("output pair not complementary");
   a_clk_high_half: assert property ($rose(ser_clk) |-> ser_clk[*5] ##1 !ser_clk)
      else $error("shift clock high phase wrong length");
   a_data_stable_high: assert property ($rose(ser_clk) |-> $stable(ser_data)[*5])
      else $error("serial data moved while shift clock high");
   a_load_bit_count: assert property ($rose(ser_load) |-> rise_cnt_reg == 5'h0e)
      else $error("load pulse not after exactly fourteen shifts");
   a_load_width: assert property ($rose(ser_load) |-> ser_load[*5] ##1 !ser_load)
      else $error("load pulse wrong width");
   a_load_clk_low: assert property (ser_load |-> !ser_clk)
      else $error("shift clock active during load pulse");
   a_load_setup: assert property ($rose(ser_load) |-> !$past(ser_clk))
      else $error("load raised too soon after shift clock");
   a_clk_idle_after: assert property ($fell(ser_load) |-> (!ser_clk)[*3])
      else $error("shift clock active right after load");

   c_load: cover property ($fell(ser_load) && par_load);
   c_par_rise: cover property ($rose(par_load));
   c_shift_one: cover property ($rose(ser_clk) && ser_data);
endmodule

// file: tb/synth_divider_config_port_tb.sv
`timescale 1ns/100ps
module synth_divider_config_port_tb;
   import sdc_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [8:0]  loop_cfg;
   logic [1:0]  odiv_cfg;
   logic [2:0]  mon_cfg;
   logic        bypass;
   logic [31:0] rdat;
   logic        rerr;
   logic [2:0]  m;
   logic [13:0] words [0:6];
   int          n_errors;
   int          tests_run;
   int          n_tog;

   sdc_link_if link_i ();
   sdc_host sdc_host_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i));
   sdc_device sdc_device_i (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link_i),
      .loop_cfg(loop_cfg), .odiv_cfg(odiv_cfg), .mon_cfg(mon_cfg), .bypass(bypass));
   sdc_link_sva sdc_link_sva_i (.pclk(pclk), .presetn(presetn), .par_load(link_i.par_load),
      .ser_clk(link_i.ser_clk), .ser_data(link_i.ser_data), .ser_load(link_i.ser_load),
      .synth_out(link_i.synth_out), .synth_out_n(link_i.synth_out_n));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task end_sim();
      $display("mismatches %0d of %0d comparisons", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // counts level changes of the monitor pin or of synth_out over a window
   task count_edges(input logic sel_mon, input int cycles, output int n);
      logic prev;
      logic cur;
      prev = sel_mon ? link_i.monitor : link_i.synth_out;
      n = 0;
      repeat (cycles) begin
         @(posedge pclk);
         cur = sel_mon ? link_i.monitor : link_i.synth_out;
         if (cur !== prev) n++;
         prev = cur;
      end
   endtask

   task wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0);
         n++;
      end while (rdat[STAT_BUSY_BIT] !== 1'b0 && n < 200);
      chk(rdat[STAT_BUSY_BIT], 1'b0, "loader stuck busy");
      repeat (6) @(posedge pclk);
   endtask

   task ser(input logic [13:0] w);
      apb(1'b1, REG_SER, {18'h0, w});
      chk(rerr, 1'b0, "serial write refused");
      wait_idle();
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      n_errors  = 0;
      tests_run = 0;
      presetn   = 1'b0;
      ce        = 1'b1;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      words     = '{{3'h1, 2'h1, 9'h0c8}, {3'h6, 2'h0, 9'h12c}, {3'h0, 2'h3, 9'h101},
                    {3'h4, 2'h2, 9'h180}, {3'h2, 2'h1, 9'h0e6}, {3'h3, 2'h0, 9'h15e},
                    {3'h5, 2'h2, 9'h190}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset state: strobe low, latches follow the parallel pins
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rdat, 32'h0, "ctrl reset");
      apb(1'b0, REG_PAR, 32'h0);
      chk(rdat, {21'h0, PAR_ODIV_RST, PAR_LOOP_RST}, "par reset");
      chk(loop_cfg, PAR_LOOP_RST, "loop follows pins");
      chk(mon_cfg, MON_SHIFT_OUT, "monitor select forced");
      chk(link_i.monitor, 1'b0, "monitor shows top shift bit");
      $display("test reset done");
      // parallel path: transparent while low, captured at the rise
      apb(1'b1, REG_PAR, {21'h0, 2'h3, 9'h106});
      repeat (6) @(posedge pclk);
      chk(loop_cfg, 9'h106, "loop transparent");
      chk(odiv_cfg, 2'h3, "output select transparent");
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (6) @(posedge pclk);
      apb(1'b1, REG_PAR, {21'h0, 2'h1, 9'h190});
      repeat (6) @(posedge pclk);
      chk(loop_cfg, 9'h106, "loop held after strobe rise");
      chk(odiv_cfg, 2'h3, "output select held");
      chk(link_i.loop_par, 9'h190, "pins follow register");
      count_edges(1'b0, 2048, n_tog);
      chk(n_tog, 2048 * 262 / (REF_DIV * VCO_SCALE * 8), "output toggle count");
      ce <= 1'b0;
      @(posedge pclk);
      count_edges(1'b0, 64, n_tog);
      ce <= 1'b1;
      chk(n_tog, 0, "output moved while frozen");
      $display("test parallel done");
      // serial loads of every field layout and of monitor select codes 000 to 110 (111 is not in words)
      foreach (words[i]) begin
         m = words[i][13:11];
         ser(words[i]);
         chk(mon_cfg, m, "monitor select");
         chk(odiv_cfg, words[i][10:9], "output select");
         chk(loop_cfg, words[i][8:0], "loop divider");
         chk(bypass, m == MON_BYPASS, "bypass flag");
         if (m == MON_SHIFT_OUT || m == MON_HIGH || m == MON_LOW) begin
            apb(1'b0, REG_STAT, 32'h0);
            chk(rdat[STAT_MON_BIT], m == MON_HIGH, "monitor level");
         end
         if (m == MON_REF) begin
            count_edges(1'b1, 2048, n_tog);
            chk(n_tog, 2048 * 2 / REF_DIV, "reference toggles");
         end
         if (m == MON_FOUT) begin
            count_edges(1'b1, 2048, n_tog);
            chk(n_tog, 2048 * words[i][8:0] /
                (REF_DIV * VCO_SCALE * (1 << words[i][10:9])), "monitor output toggles");
         end
         if (m == MON_BYPASS) begin
            count_edges(1'b0, 64, n_tog);
            chk(n_tog, 0, "output moved without shift clock");
            // reload the same word: its fourteen shift clock rises drive the dividers
            fork
               ser(words[i]);
               count_edges(1'b0, 400, n_tog);
            join
            chk(n_tog, SHIFT_W / 2, "bypass output toggles");
         end
      end
      // a second serial write while busy is refused
      apb(1'b1, REG_SER, {18'h0, 3'h7, 2'h2, 9'h190});
      apb(1'b1, REG_SER, {18'h0, 3'h1, 2'h0, 9'h0c8});
      chk(rerr, 1'b1, "busy write accepted");
      wait_idle();
      chk(mon_cfg, 3'h7, "refused word took effect");
      $display("test serial done");
      // strobe low: parallel wins, monitor select forced, top bit shown
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (6) @(posedge pclk);
      chk(mon_cfg, MON_SHIFT_OUT, "monitor select not forced");
      chk(loop_cfg, 9'h190, "parallel loop not applied");
      chk(odiv_cfg, 2'h1, "parallel select not applied");
      apb(1'b0, REG_STAT, 32'h0);
      chk(rdat[STAT_MON_BIT], 1'b1, "monitor not top shift bit");
      ser({3'h1, 2'h3, 9'h0fa});
      chk(mon_cfg, MON_SHIFT_OUT, "serial load with strobe low");
      chk(loop_cfg, 9'h190, "serial loop with strobe low");
      apb(1'b0, REG_STAT, 32'h0);
      chk(rdat[STAT_MON_BIT], 1'b1, "shift with strobe low");
      $display("test precedence done");
      // unmapped addresses
      apb(1'b0, 8'h10, 32'h0);
      chk(rerr, 1'b1, "unmapped read error");
      chk(rdat, 32'h0, "unmapped read data");
      apb(1'b1, 8'h14, 32'hffff_ffff);
      chk(rerr, 1'b1, "unmapped write error");
      $display("test unmapped done");
      end_sim();
   end
endmodule
